/* rtl/pmc_regs.sv */
// Notes on behaviour
// (R1) controller never writes unlisted register addresses
// (R2) config at pointer zero, resets to 4127h
// (R3) bit 15 write resets all, self clears
// (R4) config bits 14-13 always read 10b
// (R5) bit 12 selects shunt full-scale range
// (R6) bits 11-9 select averaged sample count
// (R7) results update only after full averaging
// (R8) bits 8-6 select bus conversion time
// (R9) bits 5-3 select shunt conversion time
// (R10) mode field: shutdown, single shot, continuous
// (R11) registers 1h-7h present, reset to zero
// (R12) read-only identity registers at 3Eh, 3Fh
// (R13) words transferred most significant byte first
// (R14) general call then 06h does soft reset
// (R15) single shot done, idle until retriggered
// (R16) config write restarts conversion sequence
`timescale 1ns/1ps
module pmc_regs #(
	parameter int unsigned CYC_PER_US = pmc_pkg::CYC_PER_US, // lower to shorten conversions in simulation
	parameter logic [15:0] MAKER_ID = 16'h0A5A, // arbitrary value
	parameter logic [15:0] PART_ID = 16'h0B6B // arbitrary value
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// decoded serial link
	input pmc_pkg::pmc_link_s lnk,
	output logic [7:0] rd_byte_r,
	output logic rd_valid_r,
	// measurement front end
	input pmc_pkg::pmc_meas_s meas,
	output logic [1:0] meas_phase_r,
	output logic result_update_r,
	output logic shunt_range_r
);
	// -------------------------------------------------------------
	// helper functions
	// -------------------------------------------------------------
	// conversion time in cycles minus one, counted down to zero
	function automatic logic [23:0] conv_load(input logic [2:0] code);
		conv_load = 24'(pmc_pkg::CONV_TIME_US[code] * CYC_PER_US - 1);
	endfunction : conv_load
	function automatic logic is_shut(input logic [2:0] m);
		is_shut = (m[1:0] == 2'h0);
	endfunction : is_shut
	function automatic logic is_cont(input logic [2:0] m);
		is_cont = m[2] && !is_shut(m);
	endfunction : is_cont
	function automatic logic wants_shunt(input logic [2:0] m);
		wants_shunt = m[0] && (m != 3'h7);
	endfunction : wants_shunt
	function automatic logic wants_bus(input logic [2:0] m);
		wants_bus = m[1];
	endfunction : wants_bus
	// divide an accumulated sum by the sample count
	function automatic logic [15:0] avg_of(input logic signed [26:0] s, input logic [3:0] sh);
		logic signed [26:0] t;
		t = s >>> sh;
		avg_of = t[15:0];
	endfunction : avg_of

	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	pmc_pkg::pmc_cfg_s cfg_r; // configuration register
	logic [7:0] ptr_r; // register pointer
	logic [1:0] wr_idx_r; // position within a write transaction
	logic [7:0] msb_hold_r; // first data byte of a write
	logic gcall_r; // current transaction is general call
	logic rd_half_r; // next read byte is the low byte
	logic [7:0] rd_lsb_r; // low byte captured with the high byte
	logic soft_rst_r; // one cycle soft reset pulse
	logic [15:0] scale_r; // scale_factor
	logic [15:0] alert_r; // alert_select
	logic [15:0] thresh_r; // threshold_value
	logic [15:0] res_shunt_r; // shunt_reading
	logic [15:0] res_bus_r; // bus_reading
	logic [15:0] res_power_r; // power_result
	logic [15:0] res_current_r; // current_result
	pmc_pkg::pmc_state_e st_r; // conversion sequencer
	logic [23:0] cnt_r; // conversion time counter
	logic trig_r; // pending single shot start
	logic signed [26:0] acc_sh_r; // shunt sample sum
	logic signed [26:0] acc_bus_r; // bus sample sum
	logic [10:0] rounds_r; // completed rounds in this average
	logic [15:0] wr_word; // word assembled from a write
	logic wr_commit; // a full word was written
	logic cfg_wr; // that word targets the config register
	logic gc_reset; // general call reset byte seen
	logic gc_start; // general call conversion start
	logic restart; // sequence restart request
	logic [2:0] mode_new; // mode after this cycle's write
	logic [15:0] rd_word; // register at the pointer
	logic [3:0] avg_sh; // averaging shift
	logic [10:0] target; // rounds per average
	logic shunt_done, bus_done, round_done, avg_done;
	pmc_pkg::pmc_state_e first_st; // first phase of a round
	logic [23:0] first_cnt;
	logic signed [26:0] acc_sh_nxt, acc_bus_nxt;

	// -------------------------------------------------------------
	// link decode
	// -------------------------------------------------------------
	assign wr_word = {msb_hold_r, lnk.wr_byte}; // see (R13)
	assign wr_commit = lnk.wr_valid && !gcall_r && (wr_idx_r == pmc_pkg::WR_IDX_LSB);
	assign cfg_wr = wr_commit && (ptr_r == pmc_pkg::PTR_CONFIG); // see (R2)
	assign gc_reset = lnk.wr_valid && gcall_r && (wr_idx_r == pmc_pkg::WR_IDX_PTR)
		&& (lnk.wr_byte == pmc_pkg::GCALL_RESET_BYTE); // see (R14)
	assign gc_start = lnk.start && lnk.gcall && lnk.rw;
	assign restart = cfg_wr || gc_start; // see (R16)
	assign mode_new = cfg_wr ? wr_word[2:0] : cfg_r.mode;
	assign shunt_range_r = cfg_r.shunt_range_select; // see (R5)

	// transaction position, read byte pairing
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_idx_r <= pmc_pkg::WR_IDX_PTR;
			gcall_r <= 1'b0;
			rd_half_r <= 1'b0;
			rd_lsb_r <= 8'h00;
			rd_byte_r <= 8'h00;
			rd_valid_r <= 1'b0;
			msb_hold_r <= 8'h00;
		end
		else
		begin
			// a start in the same cycle wins, so that request gets no answer
			rd_valid_r <= lnk.rd_req && !gcall_r && !lnk.start;
			if (lnk.start)
			begin
				// every transaction starts over at the pointer byte
				wr_idx_r <= pmc_pkg::WR_IDX_PTR;
				gcall_r <= lnk.gcall;
				rd_half_r <= 1'b0;
			end
			else if (lnk.wr_valid && wr_idx_r != pmc_pkg::WR_IDX_DONE)
				wr_idx_r <= wr_idx_r + 2'h1;
			if (lnk.wr_valid && wr_idx_r == pmc_pkg::WR_IDX_MSB)
				msb_hold_r <= lnk.wr_byte;
			if (lnk.rd_req && !gcall_r && !lnk.start)
			begin
				// high byte first; low byte taken at the same instant
				if (!rd_half_r)
				begin
					rd_byte_r <= rd_word[15:8]; // see (R13)
					rd_lsb_r <= rd_word[7:0];
				end
				else
					rd_byte_r <= rd_lsb_r;
				rd_half_r <= !rd_half_r;
			end
		end
	end

	// register pointer, returns to zero on soft reset
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			ptr_r <= pmc_pkg::PTR_CONFIG;
		else if (soft_rst_r)
			ptr_r <= pmc_pkg::PTR_CONFIG;
		else if (lnk.wr_valid && !gcall_r && wr_idx_r == pmc_pkg::WR_IDX_PTR)
			ptr_r <= lnk.wr_byte;
	end

	// soft reset pulse from the reset bit or general call
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			soft_rst_r <= 1'b0;
		else
			soft_rst_r <= (cfg_wr && wr_word[15]) || gc_reset; // see (R3) see (R14)
	end

	// -------------------------------------------------------------
	// register file
	// -------------------------------------------------------------
	// configuration register; reset bit and reserved bits fixed
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cfg_r <= pmc_pkg::pmc_cfg_s'(pmc_pkg::CONFIG_RESET); // see (R2)
		else if (soft_rst_r)
			cfg_r <= pmc_pkg::pmc_cfg_s'(pmc_pkg::CONFIG_RESET); // see (R3)
		else if (cfg_wr)
			cfg_r <= pmc_pkg::pmc_cfg_s'({1'b0, pmc_pkg::CFG_RSVD_VAL, wr_word[12:0]}); // see (R4)
	end

	// writable scale, alert and threshold registers
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scale_r <= pmc_pkg::RESULT_RESET;
			alert_r <= pmc_pkg::RESULT_RESET;
			thresh_r <= pmc_pkg::RESULT_RESET;
		end
		else if (soft_rst_r)
		begin
			// soft reset is synchronous, kept apart from the async branch
			scale_r <= pmc_pkg::RESULT_RESET;
			alert_r <= pmc_pkg::RESULT_RESET;
			thresh_r <= pmc_pkg::RESULT_RESET;
		end
		else if (wr_commit)
		begin
			case (ptr_r)
				pmc_pkg::PTR_SCALE: scale_r <= {1'b0, wr_word[14:0]}; // top bit reserved
				pmc_pkg::PTR_ALERT: alert_r <= wr_word;
				pmc_pkg::PTR_THRESH: thresh_r <= wr_word;
				default: ; // read-only or unlisted: write dropped, see (R1)
			endcase
		end
	end

	// read mux; unlisted addresses read zero
	always_comb
	begin
		case (ptr_r)
			pmc_pkg::PTR_CONFIG: rd_word = cfg_r;
			pmc_pkg::PTR_SHUNT: rd_word = res_shunt_r; // see (R11)
			pmc_pkg::PTR_BUS: rd_word = res_bus_r;
			pmc_pkg::PTR_POWER: rd_word = res_power_r;
			pmc_pkg::PTR_CURRENT: rd_word = res_current_r;
			pmc_pkg::PTR_SCALE: rd_word = scale_r;
			pmc_pkg::PTR_ALERT: rd_word = alert_r;
			pmc_pkg::PTR_THRESH: rd_word = thresh_r;
			pmc_pkg::PTR_MAKER: rd_word = MAKER_ID; // see (R12)
			pmc_pkg::PTR_PART: rd_word = PART_ID;
			default: rd_word = 16'h0000;
		endcase
	end

	// -------------------------------------------------------------
	// conversion sequencer
	// -------------------------------------------------------------
	assign avg_sh = 4'(pmc_pkg::AVG_SHIFT[cfg_r.average_count]); // see (R6)
	assign target = 11'h001 << avg_sh;
	assign shunt_done = (st_r == pmc_pkg::ST_SHUNT) && (cnt_r == 24'h000000);
	assign bus_done = (st_r == pmc_pkg::ST_BUS) && (cnt_r == 24'h000000);
	assign round_done = (shunt_done && !wants_bus(cfg_r.mode)) || bus_done;
	assign avg_done = round_done && (rounds_r == target - 11'h001); // see (R7)
	assign first_st = wants_shunt(cfg_r.mode) ? pmc_pkg::ST_SHUNT : pmc_pkg::ST_BUS;
	assign first_cnt = wants_shunt(cfg_r.mode) ? conv_load(cfg_r.shunt_conv_time)
		: conv_load(cfg_r.bus_conv_time); // see (R8) see (R9)

	// phase state, conversion timer, pending single shot
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r <= pmc_pkg::ST_IDLE;
			cnt_r <= 24'h000000;
			trig_r <= 1'b0;
		end
		else if (soft_rst_r)
		begin
			st_r <= pmc_pkg::ST_IDLE;
			cnt_r <= 24'h000000;
			trig_r <= 1'b0;
		end
		else if (restart)
		begin
			// drop the running round; new settings apply next cycle
			st_r <= pmc_pkg::ST_IDLE; // see (R16)
			trig_r <= !is_shut(mode_new) && !is_cont(mode_new); // see (R10)
		end
		else
		begin
			case (st_r)
				pmc_pkg::ST_IDLE:
				begin
					// shutdown never leaves idle
					if (is_cont(cfg_r.mode) || trig_r) // see (R10)
					begin
						trig_r <= 1'b0;
						st_r <= first_st;
						cnt_r <= first_cnt;
					end
				end
				pmc_pkg::ST_SHUNT, pmc_pkg::ST_BUS:
				begin
					if (cnt_r != 24'h000000)
						cnt_r <= cnt_r - 24'h000001;
					else if (shunt_done && wants_bus(cfg_r.mode))
					begin
						st_r <= pmc_pkg::ST_BUS;
						cnt_r <= conv_load(cfg_r.bus_conv_time); // see (R8)
					end
					else if (avg_done && !is_cont(cfg_r.mode))
						st_r <= pmc_pkg::ST_IDLE; // see (R15)
					else
					begin
						st_r <= first_st;
						cnt_r <= first_cnt;
					end
				end
				default: st_r <= pmc_pkg::ST_IDLE;
			endcase
		end
	end

	// sample accumulation
	always_comb
	begin
		acc_sh_nxt = acc_sh_r;
		acc_bus_nxt = acc_bus_r;
		if (shunt_done)
			acc_sh_nxt = acc_sh_r + {{11{meas.shunt[15]}}, meas.shunt};
		if (bus_done)
			acc_bus_nxt = acc_bus_r + {11'h000, meas.bus};
	end

	// sums and round count; cleared on every restart
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			acc_sh_r <= 27'sh0;
			acc_bus_r <= 27'sh0;
			rounds_r <= 11'h000;
		end
		else if (soft_rst_r || restart || avg_done)
		begin
			acc_sh_r <= 27'sh0;
			acc_bus_r <= 27'sh0;
			rounds_r <= 11'h000;
		end
		else
		begin
			acc_sh_r <= acc_sh_nxt;
			acc_bus_r <= acc_bus_nxt;
			if (round_done)
				rounds_r <= rounds_r + 11'h001;
		end
	end

	// result registers, loaded only when an average completes
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			res_shunt_r <= pmc_pkg::RESULT_RESET; // see (R11)
			res_bus_r <= pmc_pkg::RESULT_RESET;
			res_power_r <= pmc_pkg::RESULT_RESET;
			res_current_r <= pmc_pkg::RESULT_RESET;
		end
		else if (soft_rst_r)
		begin
			// soft reset clears results as power-on does
			res_shunt_r <= pmc_pkg::RESULT_RESET; // see (R11)
			res_bus_r <= pmc_pkg::RESULT_RESET;
			res_power_r <= pmc_pkg::RESULT_RESET;
			res_current_r <= pmc_pkg::RESULT_RESET;
		end
		else if (avg_done && !restart)
		begin
			if (wants_shunt(cfg_r.mode))
				res_shunt_r <= avg_of(acc_sh_nxt, avg_sh); // see (R7)
			if (wants_bus(cfg_r.mode))
				res_bus_r <= avg_of(acc_bus_nxt, avg_sh);
			res_power_r <= meas.power;
			res_current_r <= meas.current;
		end
	end

	// status outputs toward the front end
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meas_phase_r <= 2'h0;
			result_update_r <= 1'b0;
		end
		else
		begin
			meas_phase_r <= {st_r == pmc_pkg::ST_BUS, st_r == pmc_pkg::ST_SHUNT};
			result_update_r <= avg_done && !restart && !soft_rst_r;
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence seq_soft_then_default;
		soft_rst_r ##1 (cfg_r == pmc_pkg::CONFIG_RESET);
	endsequence
	sequence seq_read_high;
		lnk.rd_req && !gcall_r && !lnk.start && !rd_half_r;
	endsequence

	chk_cfg_default: assert property (soft_rst_r |=> cfg_r == pmc_pkg::CONFIG_RESET) // see (R2)
		else $error("config not at default after soft reset");
	chk_bit15_reset: assert property ((cfg_wr && wr_word[15] && !soft_rst_r) |=> seq_soft_then_default) // see (R3)
		else $error("reset bit did not reset config");
	chk_rsvd_read: assert property (ptr_r == pmc_pkg::PTR_CONFIG |-> rd_word[15:13] == 3'h2) // see (R4)
		else $error("config reserved bits wrong");
	chk_range_write: assert property ((cfg_wr && !soft_rst_r) |=> shunt_range_r == $past(wr_word[12])) // see (R5)
		else $error("range bit not taken");
	chk_result_hold: assert property ((!avg_done && !soft_rst_r) |=> $stable(res_shunt_r) && $stable(res_bus_r)) // see (R7)
		else $error("results changed before average done");
	chk_avg_rounds: assert property (round_done |-> rounds_r < target) // see (R6)
		else $error("averaging overran its count");
	chk_bus_time: assert property ((st_r != pmc_pkg::ST_BUS ##1 st_r == pmc_pkg::ST_BUS)
		|-> cnt_r == conv_load(cfg_r.bus_conv_time)) // see (R8)
		else $error("bus conversion time wrong");
	chk_shunt_time: assert property ((st_r != pmc_pkg::ST_SHUNT ##1 st_r == pmc_pkg::ST_SHUNT)
		|-> cnt_r == conv_load(cfg_r.shunt_conv_time)) // see (R9)
		else $error("shunt conversion time wrong");
	chk_shutdown_idle: assert property (is_shut(cfg_r.mode) |-> st_r == pmc_pkg::ST_IDLE) // see (R10)
		else $error("sequencer running in shutdown");
	chk_regs_zero: assert property (soft_rst_r |=> scale_r == 16'h0000 && res_bus_r == 16'h0000) // see (R11)
		else $error("registers not cleared");
	chk_id_read: assert property (((ptr_r == pmc_pkg::PTR_MAKER) ##0 seq_read_high)
		|=> rd_valid_r && rd_byte_r == MAKER_ID[15:8]) // see (R12) see (R13)
		else $error("identity high byte wrong");
	chk_gcall_reset: assert property (gc_reset |=> seq_soft_then_default) // see (R14)
		else $error("general call reset ignored");
	chk_single_idle: assert property ((avg_done && !restart && !is_cont(cfg_r.mode) && !soft_rst_r)
		|=> st_r == pmc_pkg::ST_IDLE && !trig_r) // see (R15)
		else $error("single shot did not stop");
	chk_cfg_restart: assert property ((cfg_wr && !soft_rst_r) |=> st_r == pmc_pkg::ST_IDLE && rounds_r == 11'h000) // see (R16)
		else $error("config write did not restart");
endmodule : pmc_regs

/* rtl/pmc_pkg.sv */
package pmc_pkg;
	// -------------------------------------------------------------
	// register pointer values
	// -------------------------------------------------------------
	localparam logic [7:0] PTR_CONFIG = 8'h00;
	localparam logic [7:0] PTR_SHUNT = 8'h01;
	localparam logic [7:0] PTR_BUS = 8'h02;
	localparam logic [7:0] PTR_POWER = 8'h03;
	localparam logic [7:0] PTR_CURRENT = 8'h04;
	localparam logic [7:0] PTR_SCALE = 8'h05;
	localparam logic [7:0] PTR_ALERT = 8'h06;
	localparam logic [7:0] PTR_THRESH = 8'h07;
	localparam logic [7:0] PTR_MAKER = 8'h3E;
	localparam logic [7:0] PTR_PART = 8'h3F;
	// -------------------------------------------------------------
	// reset values and fixed fields
	// -------------------------------------------------------------
	localparam logic [15:0] CONFIG_RESET = 16'h4127;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [1:0] CFG_RSVD_VAL = 2'h2; // bits 14-13 read back fixed
	localparam logic [7:0] GCALL_RESET_BYTE = 8'h06;
	localparam logic [1:0] WR_IDX_PTR = 2'h0; // next write byte is the pointer
	localparam logic [1:0] WR_IDX_MSB = 2'h1;
	localparam logic [1:0] WR_IDX_LSB = 2'h2;
	localparam logic [1:0] WR_IDX_DONE = 2'h3; // extra bytes ignored
	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CYC_PER_US = 1000 / CLK_PERIOD_NS;
	localparam int unsigned CONV_TIME_US [0:7] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
	localparam int unsigned AVG_SHIFT [0:7] = '{0, 2, 4, 6, 7, 8, 9, 10}; // log2 of sample count
	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_SHUNT, ST_BUS} pmc_state_e;
	typedef struct packed {
		logic soft_reset; // self clearing
		logic [1:0] rsvd;
		logic shunt_range_select;
		logic [2:0] average_count;
		logic [2:0] bus_conv_time;
		logic [2:0] shunt_conv_time;
		logic [2:0] mode;
	} pmc_cfg_s;
	typedef struct packed {
		logic start; // transaction addressed to us begins
		logic gcall; // that transaction used the general call address
		logic rw; // 1 = read
		logic wr_valid; // one byte received from controller
		logic [7:0] wr_byte;
		logic rd_req; // controller wants the next byte
	} pmc_link_s;
	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] bus;
		logic [15:0] power;
		logic [15:0] current;
	} pmc_meas_s;
endpackage : pmc_pkg

/* verif/pmc_host_model.sv */
`timescale 1ns/1ps
module pmc_host_model (
	// clock
	input logic ref_clk,
	// decoded link toward the device
	output pmc_pkg::pmc_link_s lnk,
	input logic [7:0] rd_byte_r,
	input logic rd_valid_r
);
	int idle_cycles = 0; // extra idle cycles before each link event, models a slow host

	// link starts quiet
	initial
	begin
		lnk = '0;
	end

	// host pause before the next event
	task automatic idle();
		repeat (idle_cycles) @(negedge ref_clk);
	endtask : idle

	// open a transaction; qualifiers are scrambled once start drops
	task automatic open_xfer(input logic gc, input logic rd);
		idle();
		@(negedge ref_clk);
		lnk.start = 1'b1;
		lnk.gcall = gc;
		lnk.rw = rd;
		@(negedge ref_clk);
		lnk.start = 1'b0;
		lnk.gcall = ~gc;
		lnk.rw = ~rd;
	endtask : open_xfer

	// one byte toward the device; data line no longer holds it afterwards
	task automatic send_byte(input logic [7:0] b);
		idle();
		@(negedge ref_clk);
		lnk.wr_valid = 1'b1;
		lnk.wr_byte = b;
		@(negedge ref_clk);
		lnk.wr_valid = 1'b0;
		lnk.wr_byte = ~b;
	endtask : send_byte

	// one byte from the device; no answer gives an unknown byte
	task automatic get_byte(output logic [7:0] b);
		idle();
		@(negedge ref_clk);
		lnk.rd_req = 1'b1;
		@(negedge ref_clk);
		lnk.rd_req = 1'b0;
		b = (rd_valid_r === 1'b1) ? rd_byte_r : 8'hXX;
	endtask : get_byte

	// register write: pointer, high byte, low byte
	task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d);
		// reserved locations are never written
		if ((ptr > 8'h07 && ptr < 8'h3E) || ptr > 8'h3F) return;
		open_xfer(1'b0, 1'b0);
		send_byte(ptr);
		send_byte(d[15:8]);
		send_byte(d[7:0]);
	endtask : write_reg

	// register read: set pointer, then read high then low byte
	task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
		open_xfer(1'b0, 1'b0);
		send_byte(ptr);
		open_xfer(1'b0, 1'b1);
		get_byte(d[15:8]);
		get_byte(d[7:0]);
	endtask : read_reg

	// broadcast reset and broadcast conversion start
	task automatic gcall_reset();
		open_xfer(1'b1, 1'b0);
		send_byte(pmc_pkg::GCALL_RESET_BYTE);
	endtask : gcall_reset

	task automatic gcall_start();
		open_xfer(1'b1, 1'b1);
	endtask : gcall_start
endmodule : pmc_host_model

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------
	// setup
	// ------------------------------------------------------------
	localparam int CPU = 1; // shortened microsecond
	localparam logic [15:0] MAKER_VAL = 16'h1C2D; // arbitrary value
	localparam logic [15:0] PART_VAL = 16'h2E3F; // arbitrary value
	localparam logic [1:0] PHASE [0:7] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
	logic ref_clk;
	logic arst_n;
	pmc_pkg::pmc_link_s lnk;
	pmc_pkg::pmc_meas_s meas;
	logic [7:0] rd_byte_r;
	logic rd_valid_r;
	logic [1:0] meas_phase_r;
	logic result_update_r;
	logic shunt_range_r;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int n;
	int t;
	logic [15:0] rv;

	pmc_regs #(.CYC_PER_US(CPU), .MAKER_ID(MAKER_VAL), .PART_ID(PART_VAL)) i_dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk), .rd_byte_r(rd_byte_r), .rd_valid_r(rd_valid_r),
		.meas(meas), .meas_phase_r(meas_phase_r), .result_update_r(result_update_r),
		.shunt_range_r(shunt_range_r));
	pmc_host_model i_host (.ref_clk(ref_clk), .lnk(lnk), .rd_byte_r(rd_byte_r), .rd_valid_r(rd_valid_r));

	// 10 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// hang guard; the full run takes about 36300 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 50000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
		i_host.read_reg(p, rv);
		check($sformatf("reg %h", p), rv, exp);
	endtask : rd_chk

	// cycles until the results update, capped at lim
	task automatic wait_update(input int lim);
		n = 0;
		while (result_update_r !== 1'b1 && n < lim)
		begin
			@(negedge ref_clk);
			n++;
		end
	endtask : wait_update

	task automatic win(input string nm, input int lo);
		check(nm, {15'h0, (n >= lo && n <= lo + 10)}, 16'h0001);
	endtask : win

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		arst_n = 1'b0;
		meas = {16'h1230, 16'h0450, 16'h0777, 16'h0888};
		repeat (2) @(negedge ref_clk);
		arst_n = 1'b1;
		// reset values and identity
		check("range", {15'h0, shunt_range_r}, 16'h0000);
		rd_chk(pmc_pkg::PTR_CONFIG, pmc_pkg::CONFIG_RESET);
		for (int p = 1; p < 8; p++) rd_chk(8'(p), 16'h0000);
		rd_chk(pmc_pkg::PTR_MAKER, MAKER_VAL);
		rd_chk(pmc_pkg::PTR_PART, PART_VAL);
		rd_chk(8'h20, 16'h0000);
		// writable, read-only and fixed fields, slow host
		i_host.idle_cycles = 2;
		i_host.write_reg(pmc_pkg::PTR_SCALE, 16'h1234);
		i_host.write_reg(pmc_pkg::PTR_ALERT, 16'hBEEF);
		i_host.write_reg(pmc_pkg::PTR_THRESH, 16'h5A5A);
		i_host.write_reg(pmc_pkg::PTR_SHUNT, 16'hFFFF);
		i_host.write_reg(pmc_pkg::PTR_MAKER, 16'h0000);
		i_host.write_reg(pmc_pkg::PTR_CONFIG, 16'h1ABC);
		rd_chk(pmc_pkg::PTR_SCALE, 16'h1234);
		rd_chk(pmc_pkg::PTR_ALERT, 16'hBEEF);
		rd_chk(pmc_pkg::PTR_THRESH, 16'h5A5A);
		rd_chk(pmc_pkg::PTR_SHUNT, 16'h0000);
		rd_chk(pmc_pkg::PTR_MAKER, MAKER_VAL);
		rd_chk(pmc_pkg::PTR_CONFIG, 16'h5ABC);
		check("range", {15'h0, shunt_range_r}, 16'h0001);
		i_host.idle_cycles = 0;
		// self clearing reset bit
		i_host.write_reg(pmc_pkg::PTR_CONFIG, 16'h9FFF);
		rd_chk(pmc_pkg::PTR_CONFIG, pmc_pkg::CONFIG_RESET);
		rd_chk(pmc_pkg::PTR_SCALE, 16'h0000);
		// broadcast reset
		i_host.write_reg(pmc_pkg::PTR_SCALE, 16'h0777);
		i_host.gcall_reset();
		rd_chk(pmc_pkg::PTR_SCALE, 16'h0000);
		rd_chk(pmc_pkg::PTR_CONFIG, pmc_pkg::CONFIG_RESET);
		// every mode code
		for (int m = 0; m < 8; m++)
		begin
			i_host.write_reg(pmc_pkg::PTR_CONFIG, 16'(m));
			repeat (4) @(negedge ref_clk);
			check($sformatf("phase mode %0d", m), 16'(meas_phase_r), 16'(PHASE[m]));
		end
		// conversion time codes, bus k and shunt 7-k, single shot both
		for (int k = 0; k < 8; k++)
		begin
			meas = {16'h1000 + 16'(k), 16'h0200 + 16'(k), 16'h0300 + 16'(k), 16'h0400 + 16'(k)};
			i_host.write_reg(pmc_pkg::PTR_CONFIG, {7'h00, 3'(k), 3'(7 - k), 3'h3});
			t = (pmc_pkg::CONV_TIME_US[k] + pmc_pkg::CONV_TIME_US[7 - k]) * CPU;
			wait_update(20000);
			win($sformatf("conv time %0d", k), t);
			rd_chk(pmc_pkg::PTR_SHUNT, meas.shunt);
			rd_chk(pmc_pkg::PTR_BUS, meas.bus);
			rd_chk(pmc_pkg::PTR_POWER, meas.power);
			rd_chk(pmc_pkg::PTR_CURRENT, meas.current);
		end
		// single shot stays idle until retriggered
		i_host.write_reg(pmc_pkg::PTR_CONFIG, 16'h0003);
		wait_update(400);
		@(negedge ref_clk);
		wait_update(300);
		check("idle", 16'(n), 16'h012C);
		check("idle phase", 16'(meas_phase_r), 16'h0000);
		i_host.gcall_start();
		wait_update(400);
		win("retrigger", 2 * pmc_pkg::CONV_TIME_US[0] * CPU);
		// four-sample averaging on bus only
		meas.bus = 16'h0450;
		i_host.write_reg(pmc_pkg::PTR_CONFIG, 16'h0202);
		wait_update(2000);
		win("average", 4 * pmc_pkg::CONV_TIME_US[0] * CPU);
		rd_chk(pmc_pkg::PTR_BUS, 16'h0450);
		// config rewrite mid conversion restarts the sequence
		i_host.write_reg(pmc_pkg::PTR_CONFIG, 16'h0006);
		repeat (100) @(negedge ref_clk);
		i_host.write_reg(pmc_pkg::PTR_CONFIG, 16'h0006);
		wait_update(400);
		win("restart", pmc_pkg::CONV_TIME_US[0] * CPU);
		wrap_up();
	end
endmodule : testbench
